/* src/cct_consts.svh */
`ifndef CCT_CONSTS_SVH
`define CCT_CONSTS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define CCT_ADDR_CTRL_TWO 8'h31
`define CCT_ADDR_CTRL_ONE 8'h32
`define CCT_ADDR_STATUS 8'h33
`define CCT_ADDR_CAP_A_HI 8'h34
`define CCT_ADDR_CAP_A_LO 8'h35
`define CCT_ADDR_CMP_A_HI 8'h36
`define CCT_ADDR_CMP_A_LO 8'h37
`define CCT_ADDR_CNT_HI 8'h38
`define CCT_ADDR_CNT_LO 8'h39
`define CCT_ADDR_ALT_HI 8'h3a
`define CCT_ADDR_ALT_LO 8'h3b
`define CCT_ADDR_CAP_B_HI 8'h3c
`define CCT_ADDR_CAP_B_LO 8'h3d
`define CCT_ADDR_CMP_B_HI 8'h3e
`define CCT_ADDR_CMP_B_LO 8'h3f

// ----------------------------------------------------------------
// control one bits
// ----------------------------------------------------------------
`define CCT_C1_CAP_IE 7
`define CCT_C1_CMP_IE 6
`define CCT_C1_OVF_IE 5
`define CCT_C1_FORCE_B 4
`define CCT_C1_FORCE_A 3
`define CCT_C1_LEVEL_B 2
`define CCT_C1_CAP_A_EDGE 1
`define CCT_C1_LEVEL_A 0

// ----------------------------------------------------------------
// control two bits
// ----------------------------------------------------------------
`define CCT_C2_PIN_A_EN 7
`define CCT_C2_PIN_B_EN 6
`define CCT_C2_ONE_PULSE 5
`define CCT_C2_PWM 4
`define CCT_C2_CLK_HI 3
`define CCT_C2_CLK_LO 2
`define CCT_C2_CAP_B_EDGE 1
`define CCT_C2_EXT_EDGE 0

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define CCT_ST_CAP_A 7
`define CCT_ST_CMP_A 6
`define CCT_ST_OVF 5
`define CCT_ST_CAP_B 4
`define CCT_ST_CMP_B 3
`define CCT_ST_DISABLE 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CCT_RST_CTRL 8'h00
`define CCT_RST_CMP_HI 8'h80
`define CCT_RST_CMP_LO 8'h00
`define CCT_RST_CNT 16'hfffc
`define CCT_CNT_MAX 16'hffff

`endif

/* src/cct_pkg.sv */
package cct_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CCT_CLK_DIV4 = 2'b00,
    CCT_CLK_DIV2 = 2'b01,
    CCT_CLK_DIV8 = 2'b10,
    CCT_CLK_EXT = 2'b11
  } cct_clock_select_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cct_bus_req_s;

  typedef struct packed {
    logic capture_in_a;
    logic capture_in_b;
    logic external_timer_clock;
  } cct_pins_in_s;

endpackage : cct_pkg

/* src/cct_timer.sv */
// The implementer's own choices: the placing of the registers and the plain strobed port.
`include "cct_consts.svh"

module cct_timer #(
  parameter bit HAS_EXT_CLK = 1'b1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire cct_pkg::cct_bus_req_s bus_req,
  output logic [7:0] rdata,
  input wire cct_pkg::cct_pins_in_s pins_in,
  input wire logic global_irq_mask,
  output logic compare_out_a,
  output logic compare_out_a_oe_n,
  output logic compare_out_b,
  output logic compare_out_b_oe_n,
  output logic timer_irq
);
  import cct_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_one;
  logic [7:0] ctrl_two;
  logic timer_disable;
  logic [4:0] flags;
  logic [4:0] armed;
  logic [15:0] cnt;
  logic [2:0] presc;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] capture_value_a;
  logic [15:0] capture_value_b;
  logic inhibit_a;
  logic inhibit_b;
  logic cap_a_prev;
  logic cap_b_prev;
  logic ext_prev;
  logic pin_a;
  logic pin_b;

  function automatic logic edge_seen(input logic cur, input logic prev,
                                     input logic rising);
    edge_seen = rising ? (cur & ~prev) : (~cur & prev);
  endfunction : edge_seen

  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction : flag_next

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic acc = bus_req.wr | bus_req.rd;
  wire logic wr_c1 = bus_req.wr && bus_req.addr == `CCT_ADDR_CTRL_ONE;
  wire logic wr_c2 = bus_req.wr && bus_req.addr == `CCT_ADDR_CTRL_TWO;
  wire logic wr_st = bus_req.wr && bus_req.addr == `CCT_ADDR_STATUS;
  wire logic rd_st = bus_req.rd && bus_req.addr == `CCT_ADDR_STATUS;
  wire logic wr_ca_hi = bus_req.wr && bus_req.addr == `CCT_ADDR_CMP_A_HI;
  wire logic wr_ca_lo = bus_req.wr && bus_req.addr == `CCT_ADDR_CMP_A_LO;
  wire logic wr_cb_hi = bus_req.wr && bus_req.addr == `CCT_ADDR_CMP_B_HI;
  wire logic wr_cb_lo = bus_req.wr && bus_req.addr == `CCT_ADDR_CMP_B_LO;
  wire logic acc_cap_a_lo = acc && bus_req.addr == `CCT_ADDR_CAP_A_LO;
  wire logic acc_cap_b_lo = acc && bus_req.addr == `CCT_ADDR_CAP_B_LO;
  wire logic acc_cmp_a_lo = acc && bus_req.addr == `CCT_ADDR_CMP_A_LO;
  wire logic acc_cmp_b_lo = acc && bus_req.addr == `CCT_ADDR_CMP_B_LO;
  wire logic acc_cnt_lo = acc && bus_req.addr == `CCT_ADDR_CNT_LO;
  wire logic wr_cnt_rst = bus_req.wr &&
    (bus_req.addr == `CCT_ADDR_CNT_LO || bus_req.addr == `CCT_ADDR_ALT_LO);

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire logic pwm_mode = ctrl_two[`CCT_C2_PWM];
  wire logic opm_mode = ctrl_two[`CCT_C2_ONE_PULSE] & ~pwm_mode;
  wire logic level_a = ctrl_one[`CCT_C1_LEVEL_A];
  wire logic level_b = ctrl_one[`CCT_C1_LEVEL_B];
  wire logic force_compare_a = ctrl_one[`CCT_C1_FORCE_A];
  wire logic force_compare_b = ctrl_one[`CCT_C1_FORCE_B];
  wire logic compare_pin_a_enable = ctrl_two[`CCT_C2_PIN_A_EN];
  wire logic compare_pin_b_enable = ctrl_two[`CCT_C2_PIN_B_EN];
  wire cct_clock_select_e clock_select =
    cct_clock_select_e'(ctrl_two[`CCT_C2_CLK_HI:`CCT_C2_CLK_LO]);

  // ----------------------------------------------------------------
  // prescaler and external clock
  // ----------------------------------------------------------------
  wire logic ext_edge = edge_seen(pins_in.external_timer_clock, ext_prev,
                                  ctrl_two[`CCT_C2_EXT_EDGE]);
  logic sel_tick;
  always_comb begin
    case (clock_select)
      CCT_CLK_DIV2: sel_tick = presc[0];
      CCT_CLK_DIV4: sel_tick = &presc[1:0];
      CCT_CLK_DIV8: sel_tick = &presc;
      CCT_CLK_EXT: sel_tick = HAS_EXT_CLK & ext_edge;
      default: sel_tick = 1'b0;
    endcase
  end
  wire logic tick = sel_tick & ~timer_disable;

  // ----------------------------------------------------------------
  // edges, matches and counter
  // ----------------------------------------------------------------
  wire logic cap_a_edge = edge_seen(pins_in.capture_in_a, cap_a_prev,
                                    ctrl_one[`CCT_C1_CAP_A_EDGE]);
  wire logic cap_b_edge = edge_seen(pins_in.capture_in_b, cap_b_prev,
                                    ctrl_two[`CCT_C2_CAP_B_EDGE]);
  wire logic cap_a_evt = cap_a_edge & ~pwm_mode;
  wire logic opm_trig = cap_a_evt & opm_mode;
  wire logic [15:0] cnt_inc = cnt + 16'h0001;
  wire logic match_a = tick && !inhibit_a && cnt_inc == compare_value_a;
  wire logic match_b = tick && !inhibit_b && cnt_inc == compare_value_b;
  wire logic pwm_period = match_b & pwm_mode;
  wire logic overflow = tick && cnt == `CCT_CNT_MAX;
  wire logic cnt_reload = wr_cnt_rst | opm_trig | pwm_period;
  wire logic [15:0] next_cnt = cnt_reload ? `CCT_RST_CNT :
                               tick ? cnt_inc : cnt;

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  wire logic [4:0] flag_set = {
    cap_a_evt | pwm_period,
    match_a & ~pwm_mode,
    overflow,
    cap_b_edge,
    match_b & ~pwm_mode
  };
  wire logic [4:0] flag_clr = armed & {
    acc_cap_a_lo, acc_cmp_a_lo, acc_cnt_lo, acc_cap_b_lo, acc_cmp_b_lo
  };
  logic [4:0] next_flags;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      next_flags[i] = flag_next(flags[i], flag_set[i], flag_clr[i]);
    end
  end
  wire logic [4:0] next_armed = rd_st ? flags : (armed & ~flag_clr);

  // ----------------------------------------------------------------
  // compare pin levels
  // ----------------------------------------------------------------
  wire logic next_pin_a =
    force_compare_a ? level_a :
    (pwm_mode | opm_mode) && (match_b || opm_trig) ? level_b :
    match_a ? level_a : pin_a;
  wire logic next_pin_b =
    force_compare_b ? level_b :
    (match_b && !pwm_mode && !opm_mode) ? level_b : pin_b;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] read_mux;
  always_comb begin
    case (bus_req.addr)
      `CCT_ADDR_CTRL_ONE: read_mux = ctrl_one;
      `CCT_ADDR_CTRL_TWO: read_mux = ctrl_two;
      `CCT_ADDR_STATUS: read_mux = {flags, timer_disable, 2'b00};
      `CCT_ADDR_CAP_A_HI: read_mux = capture_value_a[15:8];
      `CCT_ADDR_CAP_A_LO: read_mux = capture_value_a[7:0];
      `CCT_ADDR_CMP_A_HI: read_mux = compare_value_a[15:8];
      `CCT_ADDR_CMP_A_LO: read_mux = compare_value_a[7:0];
      `CCT_ADDR_CNT_HI: read_mux = cnt[15:8];
      `CCT_ADDR_CNT_LO: read_mux = cnt[7:0];
      `CCT_ADDR_ALT_HI: read_mux = cnt[15:8];
      `CCT_ADDR_ALT_LO: read_mux = cnt[7:0];
      `CCT_ADDR_CAP_B_HI: read_mux = capture_value_b[15:8];
      `CCT_ADDR_CAP_B_LO: read_mux = capture_value_b[7:0];
      `CCT_ADDR_CMP_B_HI: read_mux = compare_value_b[15:8];
      `CCT_ADDR_CMP_B_LO: read_mux = compare_value_b[7:0];
      default: read_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_one <= `CCT_RST_CTRL;
      ctrl_two <= `CCT_RST_CTRL;
      timer_disable <= 1'b0;
      flags <= 5'h00;
      armed <= 5'h00;
      rdata <= 8'h00;
    end else begin
      if (wr_c1) begin
        ctrl_one <= bus_req.wdata;
      end
      if (wr_c2) begin
        ctrl_two <= bus_req.wdata;
      end
      if (wr_st) begin
        timer_disable <= bus_req.wdata[`CCT_ST_DISABLE];
      end
      flags <= next_flags;
      armed <= next_armed;
      rdata <= bus_req.rd ? read_mux : 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      compare_value_a <= {`CCT_RST_CMP_HI, `CCT_RST_CMP_LO};
      compare_value_b <= {`CCT_RST_CMP_HI, `CCT_RST_CMP_LO};
      inhibit_a <= 1'b0;
      inhibit_b <= 1'b0;
    end else begin
      if (wr_ca_hi) begin
        compare_value_a[15:8] <= bus_req.wdata;
      end
      if (wr_ca_lo) begin
        compare_value_a[7:0] <= bus_req.wdata;
      end
      if (wr_cb_hi) begin
        compare_value_b[15:8] <= bus_req.wdata;
      end
      if (wr_cb_lo) begin
        compare_value_b[7:0] <= bus_req.wdata;
      end
      inhibit_a <= wr_ca_hi | (inhibit_a & ~wr_ca_lo);
      inhibit_b <= wr_cb_hi | (inhibit_b & ~wr_cb_lo);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt <= `CCT_RST_CNT;
      presc <= 3'h0;
      cap_a_prev <= 1'b0;
      cap_b_prev <= 1'b0;
      ext_prev <= 1'b0;
      pin_a <= 1'b0;
      pin_b <= 1'b0;
    end else begin
      cnt <= next_cnt;
      presc <= cnt_reload ? 3'h0 :
               timer_disable ? presc : presc + 3'h1;
      cap_a_prev <= pins_in.capture_in_a;
      cap_b_prev <= pins_in.capture_in_b;
      ext_prev <= pins_in.external_timer_clock;
      pin_a <= next_pin_a;
      pin_b <= next_pin_b;
    end
  end

  // capture registers are undefined after reset, so they have none
  always_ff @(posedge ref_clk) begin
    if (cap_a_evt) begin
      capture_value_a <= cnt;
    end
    if (cap_b_edge) begin
      capture_value_b <= cnt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign compare_out_a = pin_a;
  assign compare_out_b = pin_b;
  assign compare_out_a_oe_n = ~(compare_pin_a_enable & ~timer_disable);
  assign compare_out_b_oe_n = ~(compare_pin_b_enable & ~timer_disable);
  wire logic irq_src =
    (ctrl_one[`CCT_C1_CAP_IE] & (flags[4] | flags[1])) |
    (ctrl_one[`CCT_C1_CMP_IE] & (flags[3] | flags[0])) |
    (ctrl_one[`CCT_C1_OVF_IE] & flags[2]);
  assign timer_irq = irq_src & ~global_irq_mask;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_cmp_irq_gate: assert property (
    (flags[3] && ctrl_one[`CCT_C1_CMP_IE] && !global_irq_mask) |-> timer_irq)
    else $error("compare flag with enable did not raise irq");
  a_ovf_irq_gate: assert property (
    (ctrl_one[7:5] == 3'b001 && !global_irq_mask) |->
      timer_irq == flags[2])
    else $error("overflow irq does not follow flag");
  a_irq_mask_gate: assert property (
    global_irq_mask |-> !timer_irq)
    else $error("irq raised while globally masked");
  a_force_a_level: assert property (
    force_compare_a |=> compare_out_a == $past(level_a))
    else $error("forced level a not on pin a");
  a_cap_a_latch: assert property (
    cap_a_evt |=> capture_value_a == $past(cnt))
    else $error("capture a did not latch counter");
  a_ovf_flag_set: assert property (
    overflow |=> flags[2] && (cnt == 16'h0000 || $past(cnt_reload)))
    else $error("overflow not flagged on wrap");
  a_alt_no_clear: assert property (
    (flags[2] && acc && bus_req.addr == `CCT_ADDR_ALT_LO) |=> flags[2])
    else $error("alternate counter access cleared overflow");
  a_disable_freeze: assert property (
    (timer_disable && !cnt_reload) |=> $stable(cnt))
    else $error("disabled timer still counts");
  a_disable_pins: assert property (
    timer_disable |-> compare_out_a_oe_n && compare_out_b_oe_n)
    else $error("disabled timer still drives pins");
  a_cmp_inhibit: assert property (
    wr_ca_hi ##1 !wr_ca_lo [*2] |-> !match_a)
    else $error("compare a matched while suspended");
  a_clear_seq: assert property (
    (rd_st && flags[3:0] == 4'h0 && flags[4]) ##1
      (acc_cap_a_lo && !flag_set[4]) |=> !flags[4])
    else $error("status then low byte did not clear flag");
  a_ext_stop: assert property (
    (!HAS_EXT_CLK && clock_select == CCT_CLK_EXT && !cnt_reload)
      |=> $stable(cnt))
    else $error("counter ran on missing external clock");
  a_ext_tick: assert property (
    (HAS_EXT_CLK && clock_select == CCT_CLK_EXT && ext_edge &&
      !timer_disable && !cnt_reload) |=> cnt == $past(cnt) + 16'h0001)
    else $error("external edge did not advance counter");
  a_opm_start: assert property (
    (opm_trig && !force_compare_a) |=>
      compare_out_a == $past(level_b) && cnt == `CCT_RST_CNT)
    else $error("one-pulse trigger did not start pulse");
  a_pwm_reload: assert property (
    (pwm_period && !force_compare_a) |=>
      compare_out_a == $past(level_b) && cnt == `CCT_RST_CNT && flags[4])
    else $error("pwm period end did not reload");
  a_match_b_pin: assert property (
    (match_b && !pwm_mode && !opm_mode && !force_compare_b) |=>
      compare_out_b == $past(level_b))
    else $error("match b did not copy level b");
  a_force_b_level: assert property (
    force_compare_b |=> compare_out_b == $past(level_b))
    else $error("forced level b not on pin b");
  a_cap_b_flag: assert property (
    cap_b_edge |=> flags[1])
    else $error("capture b edge did not set flag");
  a_cmp_b_inhibit: assert property (
    wr_cb_hi ##1 !wr_cb_lo [*2] |-> !match_b)
    else $error("compare b matched while suspended");

  c_overflow: cover property (overflow);
  c_pwm_period: cover property (pwm_period);
  c_one_pulse: cover property (opm_trig ##[1:300] match_a);
  c_capture_b: cover property (cap_b_edge);

endmodule : cct_timer

/* verification/cct_pin_model.sv */
// ----------------------------------------------------------------
// far side: capture pins, external clock, compare pin wires
// ----------------------------------------------------------------
module cct_pin_model (
  input wire logic ref_clk,
  output cct_pkg::cct_pins_in_s pins_in,
  input wire logic compare_out_a,
  input wire logic compare_out_a_oe_n,
  input wire logic compare_out_b,
  input wire logic compare_out_b_oe_n,
  output logic pin_a,
  output logic pin_b
);
  timeunit 1ns;
  timeprecision 100ps;
  import cct_pkg::*;
  logic last_a = 1'b0;
  logic last_b = 1'b0;

  initial pins_in = '{capture_in_a: 1'b1, capture_in_b: 1'b0,
                      external_timer_clock: 1'b0};

  // released pin has no pull: show the inverse of the last level
  always @(posedge ref_clk) begin
    if (!compare_out_a_oe_n) last_a <= compare_out_a;
    if (!compare_out_b_oe_n) last_b <= compare_out_b;
  end
  assign pin_a = compare_out_a_oe_n ? ~last_a : compare_out_a;
  assign pin_b = compare_out_b_oe_n ? ~last_b : compare_out_b;

  task automatic cap_a(input logic v);
    @(posedge ref_clk) pins_in.capture_in_a <= v;
    @(posedge ref_clk);
  endtask : cap_a

  task automatic cap_b(input logic v);
    @(posedge ref_clk) pins_in.capture_in_b <= v;
    @(posedge ref_clk);
  endtask : cap_b

  // clock stands low between bursts
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge ref_clk) pins_in.external_timer_clock <= 1'b1;
      repeat (2) @(posedge ref_clk);
      pins_in.external_timer_clock <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
  endtask : ext_pulses
endmodule : cct_pin_model

/* verification/testbench.sv */
`include "cct_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import cct_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  cct_bus_req_s bus_req = '0;
  logic [7:0] rdata;
  cct_pins_in_s pins_in;
  logic global_irq_mask = 1'b0;
  logic compare_out_a;
  logic compare_out_a_oe_n;
  logic compare_out_b;
  logic compare_out_b_oe_n;
  logic timer_irq;
  logic pin_a;
  logic pin_b;
  int miscompares = 0;
  int samples_checked = 0;
  logic [7:0] st;
  logic [7:0] v0;

  always #2.5 ref_clk = ~ref_clk;

  cct_timer i_cct_timer (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .rdata(rdata), .pins_in(pins_in), .global_irq_mask(global_irq_mask),
    .compare_out_a(compare_out_a), .compare_out_a_oe_n(compare_out_a_oe_n),
    .compare_out_b(compare_out_b), .compare_out_b_oe_n(compare_out_b_oe_n),
    .timer_irq(timer_irq));

  cct_pin_model i_cct_pin_model (
    .ref_clk(ref_clk), .pins_in(pins_in), .compare_out_a(compare_out_a),
    .compare_out_a_oe_n(compare_out_a_oe_n), .compare_out_b(compare_out_b),
    .compare_out_b_oe_n(compare_out_b_oe_n), .pin_a(pin_a), .pin_b(pin_b));

  // ----------------------------------------------------------------
  // bus cycles and compare
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk) bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk) bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic stop_test;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    rd(`CCT_ADDR_CTRL_TWO, v0); check(v0, 8'h00);
    rd(`CCT_ADDR_CTRL_ONE, v0); check(v0, 8'h00);
    rd(`CCT_ADDR_CMP_A_HI, v0); check(v0, 8'h80);
    rd(`CCT_ADDR_CMP_A_LO, v0); check(v0, 8'h00);
    rd(`CCT_ADDR_CMP_B_HI, v0); check(v0, 8'h80);
    rd(8'h40, v0); check(v0, 8'h00);
    rd(`CCT_ADDR_STATUS, st); check(st & 8'h07, 8'h00);
    check({6'h00, compare_out_a_oe_n, compare_out_b_oe_n}, 8'h03);
  endtask : t_reset_values

  task automatic t_overflow;
    wr(`CCT_ADDR_CTRL_TWO, 8'h04);
    wr(`CCT_ADDR_CTRL_ONE, 8'h20);
    repeat (30) @(posedge ref_clk);
    rd(`CCT_ADDR_STATUS, st); check(st & 8'h20, 8'h20);
    check({7'h00, timer_irq}, 8'h01);
    @(posedge ref_clk) global_irq_mask <= 1'b1;
    @(posedge ref_clk) #1 check({7'h00, timer_irq}, 8'h00);
    @(posedge ref_clk) global_irq_mask <= 1'b0;
    wr(`CCT_ADDR_CTRL_ONE, 8'h00);
    #1 check({7'h00, timer_irq}, 8'h00);
    rd(`CCT_ADDR_ALT_LO, v0);
    rd(`CCT_ADDR_STATUS, st); check(st & 8'h20, 8'h20);
    rd(`CCT_ADDR_CNT_LO, v0);
    rd(`CCT_ADDR_STATUS, st); check(st & 8'h20, 8'h00);
  endtask : t_overflow

  task automatic t_compare_a;
    wr(`CCT_ADDR_CMP_A_HI, 8'h00);
    wr(`CCT_ADDR_CMP_A_LO, 8'h03);
    wr(`CCT_ADDR_CTRL_TWO, 8'h84);
    wr(`CCT_ADDR_CTRL_ONE, 8'h41);
    wr(`CCT_ADDR_CNT_LO, 8'h00);
    repeat (30) @(posedge ref_clk);
    check({7'h00, compare_out_a_oe_n}, 8'h00);
    check({7'h00, pin_a}, 8'h01);
    check({7'h00, timer_irq}, 8'h01);
    rd(`CCT_ADDR_STATUS, st); check(st & 8'h40, 8'h40);
    rd(`CCT_ADDR_CMP_A_LO, v0);
    rd(`CCT_ADDR_STATUS, st); check(st & 8'h40, 8'h00);
    wr(`CCT_ADDR_CMP_A_HI, 8'h00);
    wr(`CCT_ADDR_CNT_LO, 8'h00);
    repeat (30) @(posedge ref_clk);
    rd(`CCT_ADDR_STATUS, st); check(st & 8'h40, 8'h00);
    wr(`CCT_ADDR_CMP_A_LO, 8'h03);
  endtask : t_compare_a

  task automatic t_compare_b_force_disable;
    wr(`CCT_ADDR_CMP_B_HI, 8'h00);
    wr(`CCT_ADDR_CMP_B_LO, 8'h02);
    wr(`CCT_ADDR_CTRL_TWO, 8'hc4);
    wr(`CCT_ADDR_CTRL_ONE, 8'h04);
    wr(`CCT_ADDR_CNT_LO, 8'h00);
    repeat (30) @(posedge ref_clk);
    check({pin_a, pin_b}, 8'h01);
    rd(`CCT_ADDR_STATUS, st); check(st & 8'h08, 8'h08);
    rd(`CCT_ADDR_CMP_B_LO, v0);
    rd(`CCT_ADDR_STATUS, st); check(st & 8'h08, 8'h00);
    wr(`CCT_ADDR_CTRL_ONE, 8'h10);
    @(posedge ref_clk) #1 check({7'h00, pin_b}, 8'h00);
    wr(`CCT_ADDR_CTRL_ONE, 8'h09);
    @(posedge ref_clk) #1 check({7'h00, pin_a}, 8'h01);
    wr(`CCT_ADDR_STATUS, 8'h04);
    #1 check({compare_out_a_oe_n, compare_out_b_oe_n}, 8'h03);
    rd(`CCT_ADDR_CNT_LO, v0);
    repeat (20) @(posedge ref_clk);
    rd(`CCT_ADDR_CNT_LO, st); check(st, v0);
    wr(`CCT_ADDR_STATUS, 8'h00);
    wr(`CCT_ADDR_CTRL_ONE, 8'h00);
  endtask : t_compare_b_force_disable

  task automatic t_ext_capture;
    wr(`CCT_ADDR_CTRL_TWO, 8'h0d);
    wr(`CCT_ADDR_CTRL_ONE, 8'h02);
    wr(`CCT_ADDR_CNT_LO, 8'h00);
    i_cct_pin_model.ext_pulses(2);
    rd(`CCT_ADDR_CNT_LO, v0); check(v0, 8'hfe);
    i_cct_pin_model.cap_a(1'b0);
    rd(`CCT_ADDR_STATUS, st); check(st & 8'h80, 8'h00);
    i_cct_pin_model.cap_a(1'b1);
    rd(`CCT_ADDR_CAP_A_LO, v0); check(v0, 8'hfe);
    rd(`CCT_ADDR_CAP_A_HI, v0); check(v0, 8'hff);
    i_cct_pin_model.cap_b(1'b1);
    rd(`CCT_ADDR_STATUS, st); check(st & 8'h90, 8'h80);
    i_cct_pin_model.cap_b(1'b0);
    rd(`CCT_ADDR_STATUS, st); check(st & 8'h90, 8'h90);
    wr(`CCT_ADDR_CTRL_ONE, 8'h82);
    #1 check({7'h00, timer_irq}, 8'h01);
    rd(`CCT_ADDR_CAP_B_LO, v0);
    rd(`CCT_ADDR_STATUS, st); check(st & 8'h90, 8'h80);
  endtask : t_ext_capture

  task automatic t_modes;
    logic [7:0] n;
    wr(`CCT_ADDR_CTRL_ONE, 8'h06);
    wr(`CCT_ADDR_CTRL_TWO, 8'ha4);
    repeat (30) @(posedge ref_clk);
    check({7'h00, pin_a}, 8'h00);
    i_cct_pin_model.cap_a(1'b0);
    i_cct_pin_model.cap_a(1'b1);
    #1 check({7'h00, pin_a}, 8'h01);
    repeat (30) @(posedge ref_clk);
    check({7'h00, pin_a}, 8'h00);
    wr(`CCT_ADDR_CMP_B_HI, 8'h00);
    wr(`CCT_ADDR_CMP_B_LO, 8'h08);
    wr(`CCT_ADDR_CTRL_TWO, 8'h94);
    wr(`CCT_ADDR_CNT_LO, 8'h00);
    repeat (26) @(posedge ref_clk);
    n = 8'h00;
    repeat (48) begin
      @(posedge ref_clk) #1 n = n + {7'h00, pin_a};
    end
    check(n, 8'h1c);
  endtask : t_modes

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset_values();
    t_overflow();
    t_compare_a();
    t_compare_b_force_disable();
    t_ext_capture();
    t_modes();
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    stop_test();
  end
endmodule : testbench
